// ---- design/dms_ctrl.sv ----
// detector mode switch controller with AXI4-Lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite register port.
`default_nettype none
`include "dms_defines.svh"
module dms_ctrl #(
  parameter int CYC_PER_SEC = `DMS_CYC_PER_SEC,
  parameter int NMOD = 2,
  parameter int NREL = 4,
  parameter int NOC = 2,
  parameter int NEXP = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // front panel switches and key
  input wire logic [3:0] classSel,
  input wire logic [3:0] holesSel,
  input wire logic [3:0] modeSel,
  input wire logic [3:0] airflowDip,
  input wire logic confirmKey,
  // airflow sensor
  input wire logic [15:0] airflowMeas,
  // plug-in modules and memory card
  input wire logic [NMOD-1:0] modPresent,
  input wire logic cardPresent,
  input wire logic dateFileStart,
  input wire logic dateByteValid,
  input wire logic [7:0] dateByte,
  // output requests from alarm logic
  input wire logic [NREL-1:0] relayReq,
  input wire logic [NOC-1:0] ocReq,
  input wire logic [NEXP-1:0] expReq,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // decoded settings
  output logic [3:0] sensRange_q,
  output logic [3:0] sensStep_q,
  output logic [6:0] airTolPct_q,
  output logic [10:0] airDelaySec_q,
  // indicators and outputs
  output logic classLed_q,
  output logic holesLed_q,
  output logic [9:0] airLedBar_q,
  output logic faultLed_q,
  output logic comLed_q,
  output logic panelFault_q,
  output logic [NREL-1:0] relayOut_q,
  output logic [NOC-1:0] open_collector_outputs_q,
  output logic [NEXP-1:0] expOut_q,
  output logic [NMOD-1:0] modActive_q,
  output logic loggingActive_q,
  output logic cardDeleteFile_q
);
  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic comboBad(input logic [3:0] c,
                                    input logic [3:0] h,
                                    input logic [23:0] lim);
    logic [3:0] l;
    l = 4'hF;
    case (c)
      4'hA: l = lim[3:0];
      4'hB: l = lim[7:4];
      4'hC: l = lim[11:8];
      4'hD: l = lim[15:12];
      4'hE: l = lim[19:16];
      4'hF: l = lim[23:20];
      default: l = 4'hF;
    endcase
    return (h == 4'h0) || (h > l);
  endfunction

  // separator expected at a date file position, zero means a digit
  function automatic logic [7:0] sepAt(input logic [4:0] i);
    case (i)
      5'd2, 5'd5: sepAt = 8'h3A;
      5'd8, 5'd19: sepAt = 8'h3B;
      5'd11, 5'd14: sepAt = 8'h2E;
      default: sepAt = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // second tick and flash phase
  // ----------------------------------------------------------------
  logic [31:0] tickCnt_q;
  logic secTick;
  logic flash_q;
  assign secTick = (tickCnt_q == 32'(CYC_PER_SEC - 1));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 32'h0;
      flash_q <= 1'b0;
    end else begin
      tickCnt_q <= secTick ? 32'h0 : tickCnt_q + 32'h1;
      if (secTick) flash_q <= ~flash_q;
    end
  end

  // ----------------------------------------------------------------
  // switch decoding
  // ----------------------------------------------------------------
  logic [23:0] limits_q;
  logic [10:0] comboCnt_q;
  logic comboFault_q;
  logic bad;
  assign bad = comboBad(classSel, holesSel, limits_q);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sensRange_q <= 4'h0;
      sensStep_q <= 4'h0;
      airTolPct_q <= `DMS_TOL_00;
      airDelaySec_q <= `DMS_DLY_00;
    end else begin
      sensRange_q <= classSel;
      sensStep_q <= holesSel;
      case (airflowDip[1:0])
        2'b00: airTolPct_q <= `DMS_TOL_00;
        2'b10: airTolPct_q <= `DMS_TOL_01;
        2'b01: airTolPct_q <= `DMS_TOL_10;
        default: airTolPct_q <= `DMS_TOL_11;
      endcase
      case (airflowDip[3:2])
        2'b00: airDelaySec_q <= `DMS_DLY_00;
        2'b10: airDelaySec_q <= `DMS_DLY_01;
        2'b01: airDelaySec_q <= `DMS_DLY_10;
        default: airDelaySec_q <= `DMS_DLY_11;
      endcase
    end
  end

  // invalid pair: flash after the first delay, fault after the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comboCnt_q <= 11'd0;
      comboFault_q <= 1'b0;
      classLed_q <= 1'b0;
      holesLed_q <= 1'b0;
    end else begin
      if (!bad) comboCnt_q <= 11'd0;
      else if (secTick && !comboFault_q) comboCnt_q <= comboCnt_q + 11'd1;
      comboFault_q <= bad &&
        (comboCnt_q >= `DMS_COMBO_D1_SEC + `DMS_COMBO_D2_SEC);
      classLed_q <= bad && (comboCnt_q >= `DMS_COMBO_D1_SEC) && flash_q;
      holesLed_q <= bad && (comboCnt_q >= `DMS_COMBO_D1_SEC) && flash_q;
    end
  end

  // ----------------------------------------------------------------
  // mode selector and confirm key
  // ----------------------------------------------------------------
  dms_pkg::dms_state_t state_q;
  logic keyPrev_q, softKey_q, keyPress, initDone_q;
  logic [10:0] settleCnt_q, logoffCnt_q;
  logic logoff_q;
  logic [15:0] airRef_q;
  assign keyPress = (confirmKey && !keyPrev_q) || softKey_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyPrev_q <= 1'b0;
      state_q <= dms_pkg::DMS_OPER;
    end else begin
      keyPrev_q <= confirmKey;
      if (keyPress) begin
        case (modeSel)
          4'h0: state_q <= dms_pkg::DMS_INIT;
          4'h1: state_q <= dms_pkg::DMS_OPER;
          4'h2: state_q <= dms_pkg::DMS_ISOL;
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // initial reset: reference taken once the settle time has passed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_q <= 11'd0;
      initDone_q <= 1'b0;
      airRef_q <= 16'h0;
    end else if (keyPress && modeSel == 4'h0) begin
      settleCnt_q <= 11'd0;
      initDone_q <= 1'b0;
    end else if (state_q == dms_pkg::DMS_INIT && !initDone_q) begin
      if (settleCnt_q >= `DMS_SETTLE_SEC) begin
        airRef_q <= airflowMeas;
        initDone_q <= 1'b1;
      end else if (secTick) begin
        settleCnt_q <= settleCnt_q + 11'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // airflow supervision
  // ----------------------------------------------------------------
  logic [15:0] diff;
  logic airOut;
  logic [10:0] airCnt_q;
  logic airFault_q;
  assign diff = (airflowMeas > airRef_q) ? airflowMeas - airRef_q
                                         : airRef_q - airflowMeas;
  assign airOut = initDone_q &&
    (({8'h0, diff} * 24'd100) > ({17'h0, airTolPct_q} * {8'h0, airRef_q}));
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      airCnt_q <= 11'd0;
      airFault_q <= 1'b0;
    end else begin
      if (!airOut) airCnt_q <= 11'd0;
      else if (secTick && airCnt_q < airDelaySec_q)
        airCnt_q <= airCnt_q + 11'd1;
      airFault_q <= airOut && (airCnt_q >= airDelaySec_q);
    end
  end

  // ----------------------------------------------------------------
  // modules, card and logoff window
  // ----------------------------------------------------------------
  logic started_q, cardReg_q, missingFault_q;
  logic [NMOD-1:0] modReg_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_q <= 1'b0;
      modReg_q <= '0;
      cardReg_q <= 1'b0;
      logoff_q <= 1'b0;
      logoffCnt_q <= 11'd0;
      missingFault_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      if (!started_q) begin
        modReg_q <= modPresent;
        cardReg_q <= cardPresent;
      end else if (logoff_q) begin
        modReg_q <= modReg_q & modPresent;
        cardReg_q <= cardReg_q && cardPresent;
        if (secTick) logoffCnt_q <= logoffCnt_q + 11'd1;
        if (logoffCnt_q >= `DMS_LOGOFF_SEC) logoff_q <= 1'b0;
      end else begin
        if (cardPresent) cardReg_q <= 1'b1;
        if (keyPress && modeSel == 4'h6 &&
            state_q != dms_pkg::DMS_INIT) begin
          logoff_q <= 1'b1;
          logoffCnt_q <= 11'd0;
        end
      end
      missingFault_q <= !logoff_q && started_q &&
        ((|(modReg_q & ~modPresent)) || (cardReg_q && !cardPresent));
    end
  end

  // ----------------------------------------------------------------
  // date file parser
  // ----------------------------------------------------------------
  logic [4:0] dIdx_q;
  logic dErr_q, byteOk;
  logic [55:0] digits_q;
  logic [23:0] timeHms_q;
  logic [31:0] dateDmy_q;
  logic [7:0] sep;
  assign sep = sepAt(dIdx_q);
  assign byteOk = (sep != 8'h00) ? (dateByte == sep)
                : (dateByte >= 8'h30 && dateByte <= 8'h39);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dIdx_q <= 5'd0;
      dErr_q <= 1'b0;
      digits_q <= 56'h0;
      timeHms_q <= 24'h0;
      dateDmy_q <= 32'h0;
      cardDeleteFile_q <= 1'b0;
    end else begin
      cardDeleteFile_q <= 1'b0;
      if (dateFileStart || !cardPresent) begin
        dIdx_q <= 5'd0;
        dErr_q <= !cardPresent;
      end else if (dateByteValid && !dErr_q) begin
        if (!byteOk) dErr_q <= 1'b1;
        else if (sep == 8'h00) digits_q <= {digits_q[51:0], dateByte[3:0]};
        if (byteOk && dIdx_q == 5'd19) begin
          timeHms_q <= digits_q[55:32];
          dateDmy_q <= digits_q[31:0];
          cardDeleteFile_q <= 1'b1;
          dErr_q <= 1'b1;
        end
        dIdx_q <= dIdx_q + 5'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs and indicators
  // ----------------------------------------------------------------
  logic isol, anyFault;
  assign isol = (state_q == dms_pkg::DMS_ISOL);
  assign anyFault = comboFault_q || airFault_q || missingFault_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      relayOut_q <= '0;
      open_collector_outputs_q <= '0;
      expOut_q <= '0;
      faultLed_q <= 1'b0;
      panelFault_q <= 1'b0;
      airLedBar_q <= 10'h000;
      comLed_q <= 1'b0;
      modActive_q <= '0;
      loggingActive_q <= 1'b0;
    end else begin
      relayOut_q <= isol ? '0 : relayReq;
      open_collector_outputs_q <= isol ? '0 : ocReq;
      expOut_q <= isol ? '0 : expReq;
      faultLed_q <= isol || anyFault;
      panelFault_q <= isol || anyFault;
      if (logoff_q) airLedBar_q <= {10{flash_q}};
      else airLedBar_q <= initDone_q ? 10'h030 : 10'h000;
      modActive_q <= logoff_q ? '0 : modReg_q;
      loggingActive_q <= cardReg_q && !logoff_q;
      comLed_q <= cardReg_q && !logoff_q && flash_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awHave_q, wHave_q;
  logic [4:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready = !wHave_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 5'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMS_RESP_OKAY;
      limits_q <= `DMS_LIMITS_RST;
      softKey_q <= 1'b0;
    end else begin
      softKey_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `DMS_RESP_OKAY;
        case (awAddr_q & 5'h1C)
          `DMS_REG_CTRL:
            softKey_q <= wStrb_q[0] && wData_q[`DMS_CTRL_KEY_BIT];
          `DMS_REG_LIMITS: begin
            for (int b = 0; b < 3; b++) begin
              if (wStrb_q[b]) limits_q[b*8 +: 8] <= wData_q[b*8 +: 8];
            end
          end
          `DMS_REG_STATUS, `DMS_REG_CONFIG, `DMS_REG_AIRREF,
          `DMS_REG_TIME, `DMS_REG_DATE: ;
          default: s_axi_bresp <= `DMS_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DMS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DMS_RESP_OKAY;
      case (s_axi_araddr & 5'h1C)
        `DMS_REG_CTRL: s_axi_rdata <= 32'h0;
        `DMS_REG_LIMITS: s_axi_rdata <= {8'h0, limits_q};
        `DMS_REG_STATUS: s_axi_rdata <= {24'h0, cardReg_q, missingFault_q,
          airFault_q, comboFault_q, logoff_q, initDone_q, state_q};
        `DMS_REG_CONFIG: s_axi_rdata <= {2'h0, airDelaySec_q,
          airTolPct_q, 4'h0, sensStep_q, sensRange_q};
        `DMS_REG_AIRREF: s_axi_rdata <= {16'h0, airRef_q};
        `DMS_REG_TIME: s_axi_rdata <= {8'h0, timeHms_q};
        `DMS_REG_DATE: s_axi_rdata <= dateDmy_q;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `DMS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_init_start;
    @(posedge ref_clk) disable iff (!rst_n)
    keyPress && modeSel == 4'h0 |=> state_q == dms_pkg::DMS_INIT;
  endproperty
  a_init_start: assert property (p_init_start)
    else $error("mode 0 key did not start initial reset");

  property p_oper;
    @(posedge ref_clk) disable iff (!rst_n)
    keyPress && modeSel == 4'h1 |=> state_q == dms_pkg::DMS_OPER;
  endproperty
  a_oper: assert property (p_oper)
    else $error("mode 1 key did not restore operation");

  property p_isol_out;
    @(posedge ref_clk) disable iff (!rst_n)
    isol |=> relayOut_q == '0 && expOut_q == '0 &&
      open_collector_outputs_q == '0;
  endproperty
  a_isol_out: assert property (p_isol_out)
    else $error("output active while isolated");

  property p_isol_flt;
    @(posedge ref_clk) disable iff (!rst_n)
    isol ##1 isol |-> faultLed_q && panelFault_q;
  endproperty
  a_isol_flt: assert property (p_isol_flt)
    else $error("isolation not reported as fault");

  property p_air_fault;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(airFault_q) |-> $past(airOut) &&
      $past(airCnt_q) >= $past(airDelaySec_q);
  endproperty
  a_air_fault: assert property (p_air_fault)
    else $error("airflow fault before delay expired");

  property p_logoff;
    @(posedge ref_clk) disable iff (!rst_n)
    started_q && !logoff_q && keyPress && modeSel == 4'h6 &&
      state_q != dms_pkg::DMS_INIT |=>
      logoff_q ##1 airLedBar_q == {10{$past(flash_q)}};
  endproperty
  a_logoff: assert property (p_logoff)
    else $error("logoff window did not open");

  property p_no_missing;
    @(posedge ref_clk) disable iff (!rst_n)
    logoff_q |=> !missingFault_q;
  endproperty
  a_no_missing: assert property (p_no_missing)
    else $error("missing fault during logoff");

  property p_ignore;
    @(posedge ref_clk) disable iff (!rst_n)
    !(keyPress && modeSel <= 4'h2) |=> $stable(state_q);
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("mode changed without a defined key press");

  c_init_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(initDone_q));
  c_date_load: cover property (@(posedge ref_clk) disable iff (!rst_n)
    cardDeleteFile_q);
  c_logoff_end: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(logoff_q));
endmodule
`default_nettype wire

// ---- design/dms_defines.svh ----
// constants for the detector mode switch controller
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DMS_CLK_NS 5
`define DMS_SEC_NS 1000000000
`define DMS_CYC_PER_SEC (`DMS_SEC_NS / `DMS_CLK_NS)
`define DMS_LOGOFF_SEC 11'd15
`define DMS_SETTLE_SEC 11'd5
`define DMS_COMBO_D1_SEC 11'd10
`define DMS_COMBO_D2_SEC 11'd20
// ----------------------------------------------------------------
// airflow tables
// ----------------------------------------------------------------
`define DMS_TOL_00 7'd20
`define DMS_TOL_01 7'd30
`define DMS_TOL_10 7'd50
`define DMS_TOL_11 7'd10
`define DMS_DLY_00 11'd300
`define DMS_DLY_01 11'd600
`define DMS_DLY_10 11'd1200
`define DMS_DLY_11 11'd10
// ----------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------
`define DMS_REG_CTRL 5'h00
`define DMS_REG_LIMITS 5'h04
`define DMS_REG_STATUS 5'h08
`define DMS_REG_CONFIG 5'h0C
`define DMS_REG_AIRREF 5'h10
`define DMS_REG_TIME 5'h14
`define DMS_REG_DATE 5'h18
`define DMS_CTRL_KEY_BIT 0
`define DMS_LIMITS_RST 24'hCCCCC8
`define DMS_RESP_OKAY 2'b00
`define DMS_RESP_SLVERR 2'b10
`endif

// ---- design/dms_pkg.sv ----
// types for the detector mode switch controller
`default_nettype none
package dms_pkg;
  typedef enum logic [1:0] {
    DMS_OPER = 2'b00,
    DMS_INIT = 2'b01,
    DMS_ISOL = 2'b10
  } dms_state_t;
endpackage
`default_nettype wire

// ---- testbench/dms_ctrl_tb_top.sv ----
// self-checking bench for the mode switch controller
`default_nettype none
module dms_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  localparam int CPS = 20;
  logic ref_clk, rst_n, confirmKey, cardPresent, dateFileStart;
  logic [3:0] classSel, holesSel, modeSel, airflowDip;
  logic [3:0] relayReq, relOut, sRng, sStp, wstrb;
  logic [1:0] modPresent, ocReq, ocOut, modAct, bresp, rresp, r;
  logic [7:0] dateByte, expReq, expOut;
  logic [15:0] airflowMeas;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, fLed, pFlt, logAct, delFile, dateByteValid;
  logic clsLed, hlsLed, comLed;
  logic [6:0] tol;
  logic [10:0] dly;
  logic [9:0] bar;
  int checks, error_cnt, nCls, nCom;
  dms_ctrl #(.CYC_PER_SEC(CPS)) u_dut (
    .ref_clk, .rst_n, .classSel, .holesSel, .modeSel, .airflowDip,
    .confirmKey, .airflowMeas, .modPresent, .cardPresent, .dateFileStart,
    .dateByteValid, .dateByte, .relayReq, .ocReq, .expReq,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sensRange_q(sRng),
    .sensStep_q(sStp), .airTolPct_q(tol), .airDelaySec_q(dly),
    .classLed_q(clsLed), .holesLed_q(hlsLed), .airLedBar_q(bar),
    .faultLed_q(fLed), .comLed_q(comLed), .panelFault_q(pFlt),
    .relayOut_q(relOut),
    .open_collector_outputs_q(ocOut), .expOut_q(expOut),
    .modActive_q(modAct), .loggingActive_q(logAct),
    .cardDeleteFile_q(delFile));
  dms_operator #(.CPS(CPS)) u_op (.ref_clk, .rst_n, .classSel, .holesSel,
    .modeSel, .airflowDip, .confirmKey, .modPresent, .cardPresent);
  function automatic logic [6:0] tolOf(input logic [1:0] d);
    return d == 2'h0 ? 7'h14 : d == 2'h2 ? 7'h1E : d == 2'h1 ? 7'h32 : 7'h0A;
  endfunction
  function automatic logic [10:0] dlyOf(input logic [1:0] d);
    return d == 2'h0 ? 11'h12C : d == 2'h1 ? 11'h4B0 : d == 2'h2 ? 11'h258
      : 11'h00A;
  endfunction
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    summarize();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // handshakes are judged at the falling edge, where nothing moves any more
  task automatic axiWr(input logic [4:0] a, input logic [31:0] d,
    output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (int n = 0; n < 40 && !b; n++) begin
      @(negedge ref_clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      rs = bresp;
      @(posedge ref_clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
    if (!b) tmo();
  endtask
  task automatic axiRd(input logic [4:0] a, output logic [31:0] d,
    output logic [1:0] rs);
    logic ar, v;
    v = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int n = 0; n < 40 && !v; n++) begin
      @(negedge ref_clk);
      ar = arvalid & arready;
      v = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge ref_clk);
      if (ar) arvalid <= 1'b0;
      if (v) rready <= 1'b0;
    end
    if (!v) tmo();
  endtask
  task automatic sendDate(input string s, input int n);
    int p;
    p = 0;
    dateFileStart <= 1'b1;
    @(posedge ref_clk);
    dateFileStart <= 1'b0;
    foreach (s[i]) begin
      dateByteValid <= 1'b1;
      dateByte <= s[i];
      @(posedge ref_clk);
    end
    dateByteValid <= 1'b0;
    repeat (4) begin
      @(negedge ref_clk);
      p += delFile;
    end
    @(posedge ref_clk);
    chk(p, n);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst_n, dateFileStart, dateByteValid, dateByte, relayReq, ocReq} = '0;
    {expReq, airflowMeas, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    void'($urandom(99203));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    relayReq <= 4'($urandom) | 4'h1;
    ocReq <= 2'($urandom) | 2'h1;
    expReq <= 8'($urandom) | 8'h01;
    airflowMeas <= 16'($urandom);
    repeat (3) @(posedge ref_clk);
    chk({modAct, logAct}, 3'h7);
    for (int i = 0; i < 8; i++) begin
      u_op.classSel <= i == 0 ? 4'h2 : 4'($urandom % 10);
      u_op.holesSel <= i == 0 ? 4'hA : 4'(1 + $urandom % 15);
      u_op.airflowDip <= i == 0 ? 4'h6 : 4'($urandom);
      repeat (3) @(posedge ref_clk);
      chk(sRng, classSel);
      chk(sStp, holesSel);
      chk(tol, tolOf(airflowDip[1:0]));
      chk(dly, dlyOf(airflowDip[3:2]));
    end
    u_op.airflowDip <= 4'h0;
    u_op.holesSel <= 4'h0;
    repeat (5 * CPS) @(posedge ref_clk);
    chk({clsLed, hlsLed, pFlt}, 3'h0);
    repeat (6 * CPS) @(posedge ref_clk);
    nCls = 0;
    nCom = 0;
    // a full flash period holds exactly one second of lit samples
    repeat (2 * CPS) begin
      @(negedge ref_clk);
      nCls += clsLed & hlsLed;
      nCom += comLed;
    end
    chk(nCls, CPS);
    chk(nCom, CPS);
    repeat (20 * CPS) @(posedge ref_clk);
    axiRd(5'h08, rd, r);
    chk({rd[4], pFlt}, 2'h3);
    u_op.holesSel <= 4'h1;
    $display("decode test done");
    u_op.modeSel <= 4'h2;
    repeat (4) @(posedge ref_clk);
    chk(relOut, relayReq);
    u_op.press(4'h5);
    chk(relOut, relayReq);
    u_op.press(4'h2);
    chk({relOut, ocOut, expOut}, 14'h0);
    chk({fLed, pFlt}, 2'h3);
    u_op.press(4'h1);
    chk({relOut, ocOut, expOut}, {relayReq, ocReq, expReq});
    u_op.modeSel <= 4'h2;
    axiWr(5'h00, 32'h1, r);
    repeat (3) @(posedge ref_clk);
    chk(relOut, 4'h0);
    u_op.press(4'h1);
    $display("mode test done");
    u_op.press(4'h0);
    repeat (5 * CPS + 10) @(posedge ref_clk);
    chk(bar, 10'h030);
    axiRd(5'h10, rd, r);
    chk(rd, {16'h0, airflowMeas});
    u_op.press(4'h1);
    u_op.airflowDip <= 4'hC;
    airflowMeas <= airflowMeas ^ 16'h8000;
    repeat (5 * CPS) @(posedge ref_clk);
    chk(pFlt, 1'b0);
    repeat (6 * CPS + 10) @(posedge ref_clk);
    chk(pFlt, 1'b1);
    airflowMeas <= airflowMeas ^ 16'h8000;
    u_op.airflowDip <= 4'h0;
    $display("initial reset test done");
    sendDate("12:48:16;13.06.2015;", 1);
    axiRd(5'h14, rd, r);
    chk(rd, 32'h00124816);
    axiRd(5'h18, rd, r);
    chk(rd, 32'h13062015);
    sendDate("12:48:16;13.06-2015;", 0);
    $display("date test done");
    axiRd(5'h04, rd, r);
    chk(rd, 32'h00CCCCC8);
    wstrb <= 4'h1;
    axiWr(5'h04, 32'h00123456, r);
    wstrb <= 4'hF;
    axiRd(5'h04, rd, r);
    chk(rd, 32'h00CCCC56);
    axiRd(5'h1C, rd, r);
    chk(r, 2'h2);
    axiWr(5'h1C, 32'h5, r);
    chk(r, 2'h2);
    $display("register test done");
    u_op.press(4'h6);
    chk({modAct, logAct}, 3'h0);
    repeat (15 * CPS + 10) @(posedge ref_clk);
    chk({modAct, logAct}, 3'h7);
    u_op.press(4'h6);
    u_op.modPresent <= 2'h1;
    u_op.cardPresent <= 1'b0;
    repeat (15 * CPS + 10) @(posedge ref_clk);
    axiRd(5'h08, rd, r);
    chk({rd[6], modAct}, 3'h1);
    $display("logoff test done");
    summarize();
  end
endmodule
`default_nettype wire

// ---- testbench/dms_operator.sv ----
// operator model at the front panel switches, key and plug-ins
`default_nettype none
module dms_operator #(
  parameter int CPS = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // switches, key and plug-ins
  output var logic [3:0] classSel,
  output var logic [3:0] holesSel,
  output var logic [3:0] modeSel,
  output var logic [3:0] airflowDip,
  output var logic confirmKey,
  output var logic [1:0] modPresent,
  output var logic cardPresent
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // panel handling
  // ----------------------------------------
  int upCyc;
  initial begin
    {classSel, holesSel, airflowDip, confirmKey} = 13'h0;
    modeSel = 4'h1;
    modPresent = 2'h3;
    cardPresent = 1'b1;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upCyc <= 0;
    end else begin
      upCyc <= upCyc + 1;
    end
  end
  // key held two cycles so the edge detector sees exactly one press
  task automatic press(input logic [3:0] m);
    modeSel <= m;
    @(posedge ref_clk);
    while (m == 4'h0 && upCyc < 120 * CPS) @(posedge ref_clk);
    confirmKey <= 1'b1;
    repeat (2) @(posedge ref_clk);
    confirmKey <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire
